// file: hw/adc_serial_pkg.sv
package adc_serial_pkg;
    // frame geometry: status word, then one word per channel
    localparam int WORD_W      = 24;
    localparam int CH_NUM      = 4;
    localparam int FRAME_WORDS = CH_NUM + 1;
    localparam int FRAME_BITS  = FRAME_WORDS * WORD_W;
    localparam int CH_BITS     = CH_NUM * WORD_W;

    // result queue and command fifo
    localparam int QUEUE_DEPTH    = 2;
    localparam int CMD_FIFO_DEPTH = 16;

    // bit positions in the synchroniser vector
    localparam int PIN_CS   = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_MOSI = 2;
    localparam int PIN_MCLK = 3;
    localparam int PIN_SYNC = 4;
    localparam int PIN_NUM  = 5;

    // values after reset
    localparam logic [PIN_NUM-1:0] PINS_RST = 5'h11;
    localparam logic [6:0]         BIT_RST  = 7'h00;
    localparam logic [15:0]        MCLK_RST = 16'h0000;

    // counts of cycles
    localparam logic [6:0] FRAME_LAST = 7'(FRAME_BITS - 1);
    localparam logic [4:0] WORD_LAST  = 5'(WORD_W - 1);
    localparam logic [1:0] CS_LOW_SAT = 2'h2;
    localparam int CLK_SYS_MHZ        = 100;
    localparam int CONVERSION_READY_N_PULSE_NS      = 40;
    localparam logic [2:0] CONVERSION_READY_N_PULSE_CYC =
        3'((CONVERSION_READY_N_PULSE_NS * CLK_SYS_MHZ + 999) / 1000);

    typedef struct packed {
        logic        fault;
        logic        overflow;
        logic        empty;
        logic        crc_fault;
        logic [19:0] rsvd;
    } status_t;

    typedef logic [CH_NUM-1:0][WORD_W-1:0] chans_t;
endpackage

// file: hw/cmd_fifo.sv
module cmd_fifo #(
    parameter int W     = 24,
    parameter int DEPTH = 16
) (
    input  wire logic         clk_sys_in,
    input  wire logic         rst_n_in,
    input  wire logic         in_valid_in,
    input  wire logic [W-1:0] in_data_in,
    output logic              in_ready_out,
    output logic              out_valid_out,
    output logic [W-1:0]      out_data_out,
    input  wire logic         out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr;
        logic [AW-1:0]           rd;
        logic [AW:0]             cnt;
        logic                    ov;
        logic [W-1:0]            od;
    } fifo_state_t;

    fifo_state_t q;
    fifo_state_t n;
    logic        push;
    logic        pull;
    logic        room;

    // registered output stage keeps the port straight off a flip-flop
    always_comb begin
        n    = q;
        // the output register counts toward depth, so DEPTH words fill it
        room = (q.cnt + (AW+1)'(q.ov)) != (AW+1)'(DEPTH);
        push = in_valid_in && room;
        pull = (!q.ov || out_ready_in) && (q.cnt != '0);
        if (!q.ov || out_ready_in) begin
            n.ov = pull;
        end
        if (pull) begin
            n.od = q.mem[q.rd];
            n.rd = q.rd + 1'b1;
        end
        if (push) begin
            n.mem[q.wr] = in_data_in;
            n.wr        = q.wr + 1'b1;
        end
        n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pull);
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign in_ready_out  = room;
    assign out_valid_out = q.ov;
    assign out_data_out  = q.od;

    fifo_bound_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (q.cnt + (AW+1)'(q.ov)) <= (AW+1)'(DEPTH)
        && ((q.cnt + (AW+1)'(q.ov)) == (AW+1)'(DEPTH) -> !in_ready_out))
        else $error("command fifo count out of range");
    fifo_fill_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !in_ready_out);
endmodule

// file: hw/adc_host_serial_sync.sv
// Overview of operation
// - output released while chip select is high
// - two-entry result queue, overflow halves ready pulses
// - pop only on complete frame, else repeat
// - misaligned strobe sets the realign fault flag
// - tied-low select requires frame checksums enabled
module adc_host_serial_sync #(
    parameter logic [15:0] CONV_MCLK_CYCLES = 16'h0400
) (
    input  wire logic                               clk_sys_in,
    input  wire logic                               rst_n_in,
    input  wire logic                               cs_n_in,
    input  wire logic                               sclk_in,
    input  wire logic                               mosi_in,
    input  wire logic                               master_clock_in,
    input  wire logic                               sync_n_in,
    input  wire logic [adc_serial_pkg::CH_BITS-1:0] ch_data_in,
    input  wire logic [adc_serial_pkg::CH_NUM-1:0]  ch_en_in,
    input  wire logic                               crc_en_in,
    input  wire logic                               clear_overrun_in,
    input  wire logic                               cmd_ready_in,
    output logic                                    miso_out,
    output logic                                    miso_oe_n_out,
    output logic                                    conversion_ready_n_out,
    output logic                                    realign_fault_flag_out,
    output logic                                    overflow_out,
    output logic                                    crc_fault_out,
    output logic                                    cmd_overrun_out,
    output logic                                    cmd_valid_out,
    output logic [adc_serial_pkg::WORD_W-1:0]       cmd_word_out
);
    typedef struct packed {
        logic [adc_serial_pkg::PIN_NUM-1:0]            s1;
        logic [adc_serial_pkg::PIN_NUM-1:0]            s2;
        logic [adc_serial_pkg::PIN_NUM-1:0]            s3;
        logic [adc_serial_pkg::PIN_NUM-1:0]            filt;
        logic [15:0]                                   mclk_cnt;
        logic [adc_serial_pkg::QUEUE_DEPTH-1:0][adc_serial_pkg::CH_BITS-1:0] qd;
        logic [1:0]                                    q_cnt;
        logic                                          q_head;
        logic                                          ovf_phase;
        logic                                          ovf;
        logic                                          fault;
        logic [2:0]                                    conversion_ready_n_cnt;
        logic                                          conversion_ready_n_n;
        logic [adc_serial_pkg::FRAME_BITS-1:0]         shreg;
        logic [6:0]                                    bit_cnt;
        logic                                          active;
        logic [adc_serial_pkg::WORD_W-1:0]             rx_word;
        logic [4:0]                                    rx_bits;
        logic                                          miso;
        logic                                          miso_oe_n;
        logic [1:0]                                    cs_low_convs;
        logic                                          crc_fault;
        logic                                          overrun;
        logic                                          push_valid;
    } state_t;

    state_t                             q;
    state_t                             n;
    logic [adc_serial_pkg::PIN_NUM-1:0] agree;
    logic [adc_serial_pkg::PIN_NUM-1:0] rise;
    logic [adc_serial_pkg::PIN_NUM-1:0] fall;
    logic                               conv;
    logic                               frame_done;
    logic                               fault_set;
    logic                               fifo_ready;
    logic                               slot;

    // status word first, then channels 0..3; disabled channels still
    // occupy their slot so the frame length never changes
    function automatic logic [adc_serial_pkg::FRAME_BITS-1:0] build_frame(
        input adc_serial_pkg::chans_t               ch,
        input logic                                 have,
        input adc_serial_pkg::status_t              st,
        input logic [adc_serial_pkg::CH_NUM-1:0]    en
    );
        logic [adc_serial_pkg::FRAME_BITS-1:0] f;
        f = '0;
        f[adc_serial_pkg::FRAME_BITS-1 -: adc_serial_pkg::WORD_W] = st;
        for (int i = 0; i < adc_serial_pkg::CH_NUM; i++) begin
            if (have && en[i]) begin
                f[adc_serial_pkg::CH_BITS-1-i*adc_serial_pkg::WORD_W
                  -: adc_serial_pkg::WORD_W] = ch[i];
            end
        end
        return f;
    endfunction

    always_comb begin
        n            = q;
        n.push_valid = 1'b0;
        fault_set    = 1'b0;
        slot         = 1'b0;
        // three-stage synchroniser, a change counts once stages 2 and 3 agree
        n.s1 = {sync_n_in, master_clock_in, mosi_in, sclk_in, cs_n_in};
        n.s2 = q.s1;
        n.s3 = q.s2;
        agree  = ~(q.s2 ^ q.s3);
        n.filt = (agree & q.s3) | (~agree & q.filt);
        rise   = n.filt & ~q.filt;
        fall   = ~n.filt & q.filt;
        conv   = rise[adc_serial_pkg::PIN_MCLK] && (q.mclk_cnt == CONV_MCLK_CYCLES - 16'h0001);
        frame_done = fall[adc_serial_pkg::PIN_SCLK] && q.active && !rise[adc_serial_pkg::PIN_CS]
                     && (q.bit_cnt == adc_serial_pkg::FRAME_LAST);

        // ready pulse countdown
        if (q.conversion_ready_n_cnt != 3'h0) begin
            n.conversion_ready_n_cnt = q.conversion_ready_n_cnt - 3'h1;
        end else begin
            n.conversion_ready_n_n = 1'b1;
        end

        // conversion cadence from master clock edges
        if (rise[adc_serial_pkg::PIN_MCLK]) begin
            n.mclk_cnt = conv ? 16'h0000 : q.mclk_cnt + 16'h0001;
        end
        // strobe always restarts the cadence count; off-boundary edges also set the fault flag
        if (fall[adc_serial_pkg::PIN_SYNC]) begin
            fault_set  = (q.mclk_cnt != 16'h0000);
            n.mclk_cnt = 16'h0000;
        end

        // frame boundaries from chip select
        if (fall[adc_serial_pkg::PIN_CS]) begin
            n.active    = 1'b1;
            n.bit_cnt   = adc_serial_pkg::BIT_RST;
            n.rx_bits   = 5'h00;
            n.miso_oe_n = 1'b0;
        end
        if (rise[adc_serial_pkg::PIN_CS]) begin
            n.active       = 1'b0;
            n.miso_oe_n    = 1'b1;
            n.cs_low_convs = 2'h0;
        end

        // shift on rising sclk, sample on falling sclk
        if (q.active && !rise[adc_serial_pkg::PIN_CS]) begin
            if (rise[adc_serial_pkg::PIN_SCLK]) begin
                n.miso  = q.shreg[adc_serial_pkg::FRAME_BITS-1];
                n.shreg = {q.shreg[adc_serial_pkg::FRAME_BITS-2:0], 1'b0};
            end
            if (fall[adc_serial_pkg::PIN_SCLK]) begin
                n.rx_word = {q.rx_word[adc_serial_pkg::WORD_W-2:0], q.filt[adc_serial_pkg::PIN_MOSI]};
                n.bit_cnt = frame_done ? adc_serial_pkg::BIT_RST : q.bit_cnt + 7'h01;
                if (q.rx_bits == adc_serial_pkg::WORD_LAST) begin
                    n.rx_bits    = 5'h00;
                    n.push_valid = fifo_ready;
                    if (!fifo_ready) begin
                        n.overrun = 1'b1;
                    end
                end else begin
                    n.rx_bits = q.rx_bits + 5'h01;
                end
            end
        end
        if (clear_overrun_in && !(n.overrun && !q.overrun)) begin
            n.overrun = 1'b0;
        end

        // a result is consumed only when the whole frame went out
        if (frame_done) begin
            n.fault     = 1'b0;
            n.ovf       = 1'b0;
            n.ovf_phase = 1'b0;
            if (q.q_cnt != 2'h0) begin
                n.q_head = ~q.q_head;
                n.q_cnt  = q.q_cnt - 2'h1;
            end
        end
        // set wins over the clear done by a completed frame
        if (fault_set) begin
            n.fault = 1'b1;
        end

        // new result: queue it, or overwrite the newest on overflow
        if (conv) begin
            if (n.q_cnt != 2'h2) begin
                slot        = n.q_head ^ n.q_cnt[0];
                n.q_cnt     = n.q_cnt + 2'h1;
                n.conversion_ready_n_n    = 1'b0;
                n.conversion_ready_n_cnt  = adc_serial_pkg::CONVERSION_READY_N_PULSE_CYC - 3'h1;
            end else begin
                slot        = ~n.q_head;
                n.ovf       = 1'b1;
                n.ovf_phase = ~q.ovf_phase;
                if (q.ovf_phase) begin
                    n.conversion_ready_n_n   = 1'b0;
                    n.conversion_ready_n_cnt = adc_serial_pkg::CONVERSION_READY_N_PULSE_CYC - 3'h1;
                end
            end
            n.qd[slot] = ch_data_in;
            if (!q.filt[adc_serial_pkg::PIN_CS] && q.cs_low_convs != adc_serial_pkg::CS_LOW_SAT) begin
                n.cs_low_convs = q.cs_low_convs + 2'h1;
            end
        end

        // select held low over whole periods means tied low: checksums must be on
        n.crc_fault = (n.cs_low_convs == adc_serial_pkg::CS_LOW_SAT) && !crc_en_in;

        // load the next frame at select fall or back-to-back when tied low
        if (fall[adc_serial_pkg::PIN_CS] || frame_done) begin
            n.shreg = build_frame(n.qd[n.q_head], n.q_cnt != 2'h0,
                '{fault: n.fault, overflow: n.ovf, empty: n.q_cnt == 2'h0,
                  crc_fault: n.crc_fault, rsvd: 20'h00000}, ch_en_in);
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q           <= '0;
            q.s1        <= adc_serial_pkg::PINS_RST;
            q.s2        <= adc_serial_pkg::PINS_RST;
            q.s3        <= adc_serial_pkg::PINS_RST;
            q.filt      <= adc_serial_pkg::PINS_RST;
            q.mclk_cnt  <= adc_serial_pkg::MCLK_RST;
            q.conversion_ready_n_n    <= 1'b1;
            q.miso_oe_n <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // received host words drain through the fifo; full fifo flags overrun
    cmd_fifo #(
        .W     (adc_serial_pkg::WORD_W),
        .DEPTH (adc_serial_pkg::CMD_FIFO_DEPTH)
    ) u_cmd_fifo (
        .clk_sys_in    (clk_sys_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (q.push_valid),
        .in_data_in    (q.rx_word),
        .in_ready_out  (fifo_ready),
        .out_valid_out (cmd_valid_out),
        .out_data_out  (cmd_word_out),
        .out_ready_in  (cmd_ready_in)
    );

    assign miso_out               = q.miso;
    assign miso_oe_n_out          = q.miso_oe_n;
    assign conversion_ready_n_out = q.conversion_ready_n_n;
    assign realign_fault_flag_out = q.fault;
    assign overflow_out           = q.ovf;
    assign crc_fault_out          = q.crc_fault;
    assign cmd_overrun_out        = q.overrun;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    miso_release_a: assert property (q.filt[adc_serial_pkg::PIN_CS] |-> miso_oe_n_out)
        else $error("serial output driven while deselected");
    queue_bound_a: assert property (q.q_cnt <= 2'h2)
        else $error("result queue above two entries");
    ovf_skip_a: assert property ((conv && q.q_cnt == 2'h2 && !frame_done && !q.ovf_phase
        && q.conversion_ready_n_n) |=> conversion_ready_n_out)
        else $error("ready pulsed on skipped overflow period");
    conversion_ready_n_width_a: assert property ($fell(q.conversion_ready_n_n) |-> !q.conversion_ready_n_n[*4] ##1 q.conversion_ready_n_n)
        else $error("ready pulse width wrong");
    no_partial_pop_a: assert property ((rise[adc_serial_pkg::PIN_CS] && q.active && !conv)
        |=> q.q_cnt == $past(q.q_cnt))
        else $error("result consumed by partial frame");
    frame_pop_a: assert property ((frame_done && q.q_cnt != 2'h0 && !conv)
        |=> q.q_cnt == $past(q.q_cnt) - 2'h1)
        else $error("complete frame did not consume result");
    fault_set_a: assert property ((fall[adc_serial_pkg::PIN_SYNC] && q.mclk_cnt != 16'h0000)
        |=> realign_fault_flag_out)
        else $error("misaligned strobe not flagged");
    fault_quiet_a: assert property ((fall[adc_serial_pkg::PIN_SYNC] && q.mclk_cnt == 16'h0000
        && !q.fault) |=> !realign_fault_flag_out)
        else $error("aligned strobe flagged as fault");
    crc_flag_a: assert property ((q.cs_low_convs == adc_serial_pkg::CS_LOW_SAT && !crc_en_in
        && !rise[adc_serial_pkg::PIN_CS]) |=> crc_fault_out)
        else $error("tied-low select without checksum not flagged");

    frame_done_c: cover property (frame_done && q.q_cnt != 2'h0);
    overflow_c: cover property (conv && q.q_cnt == 2'h2);
    fault_c: cover property ($rose(q.fault));
    partial_c: cover property (rise[adc_serial_pkg::PIN_CS] && q.active && q.bit_cnt != 7'h00);
endmodule

// file: testbench/host_model.sv
module host_model (
    input  wire logic         clk_sys_in,
    input  wire logic         go_in,
    input  wire logic         tie_low_in,
    input  wire logic [6:0]   nbits_in,
    input  wire logic [119:0] tx_in,
    input  wire logic         miso_line_in,
    output logic              cs_n_out,
    output logic              sclk_out = 1'b0,
    output logic              mosi_out = 1'b0,
    output logic              busy_out = 1'b0,
    output logic              done_out = 1'b0,
    output logic [119:0]      rx_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic         cs_q = 1'b1;
    logic [119:0] rx_q;
    int           i;
    // sole device on this line, so no other select can overlap
    assign cs_n_out = cs_q & ~tie_low_in;
    // serial clock runs only inside a frame and idles low
    always begin
        @(posedge clk_sys_in);
        if (go_in) begin
            busy_out <= 1'b1;
            cs_q     <= 1'b0;
            repeat (8) @(posedge clk_sys_in);
            for (i = 0; i < int'(nbits_in); i++) begin
                sclk_out <= 1'b1;
                mosi_out <= tx_in[119 - i];
                repeat (4) @(posedge clk_sys_in);
                sclk_out <= 1'b0;
                repeat (3) @(posedge clk_sys_in);
                rx_q = {rx_q[118:0], miso_line_in}; // late: output lags the rise
                @(posedge clk_sys_in);
            end
            cs_q     <= 1'b1;
            mosi_out <= ~mosi_out; // released line shows no stale level
            rx_out   <= rx_q;
            done_out <= (nbits_in == 7'h78);
            @(posedge clk_sys_in);
            done_out <= 1'b0;
            repeat (6) @(posedge clk_sys_in);
            busy_out <= 1'b0;
        end
    end
endmodule

// file: testbench/adc_host_serial_sync_tb_top.sv
module adc_host_serial_sync_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in = 1'b0;
    logic rst_n_in, sync_n_in, crc_en_in, clear_overrun_in;
    logic master_clock_in = 1'b0;
    logic cmd_ready_in = 1'b0;
    logic [95:0]  ch_data_in;
    logic [3:0]   ch_en_in;
    logic cs_n, sclk, mosi, miso_out, miso_oe_n_out, conversion_ready_n_out;
    logic realign_fault_flag_out, overflow_out, crc_fault_out, cmd_overrun_out;
    logic cmd_valid_out, go, tie, busy, done, stall, rdy_prev;
    logic [23:0]  cmd_word_out;
    logic [6:0]   nbits;
    logic [119:0] tx_q, rx;
    logic [31:0]  seed = 32'h428E3C0D;
    logic [31:0]  rs = 32'h428E3C0D;
    logic [95:0]  data;
    logic [23:0]  exp_cmd[$];
    logic [119:0] exp_frm[$];
    int failures, total_checks, held, mdiv, mclk_edges, last_edge, ready_gap, cs_run, e0;
    wire  miso_line = miso_oe_n_out ? 1'b1 : miso_out; // pulled up when released

    adc_host_serial_sync #(.CONV_MCLK_CYCLES(16'h0008)) DUT (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n), .sclk_in(sclk),
        .mosi_in(mosi), .master_clock_in(master_clock_in), .sync_n_in(sync_n_in),
        .ch_data_in(ch_data_in), .ch_en_in(ch_en_in), .crc_en_in(crc_en_in),
        .clear_overrun_in(clear_overrun_in), .cmd_ready_in(cmd_ready_in),
        .miso_out(miso_out), .miso_oe_n_out(miso_oe_n_out),
        .conversion_ready_n_out(conversion_ready_n_out),
        .realign_fault_flag_out(realign_fault_flag_out), .overflow_out(overflow_out),
        .crc_fault_out(crc_fault_out), .cmd_overrun_out(cmd_overrun_out),
        .cmd_valid_out(cmd_valid_out), .cmd_word_out(cmd_word_out));

    host_model host (
        .clk_sys_in(clk_sys_in), .go_in(go), .tie_low_in(tie), .nbits_in(nbits),
        .tx_in(tx_q), .miso_line_in(miso_line), .cs_n_out(cs_n), .sclk_out(sclk),
        .mosi_out(mosi), .busy_out(busy), .done_out(done), .rx_out(rx));

    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] rnd();
        seed = lfsr(seed);
        return seed;
    endfunction

    // status word first, then channel 0 to 3; disabled slots read zero
    function automatic logic [119:0] frame(input logic f, o, e, input logic [95:0] d,
                                           input logic [3:0] en);
        logic [119:0] r;
        r = {f, o, e, 117'h0};
        for (int c = 0; c < 4; c++) if (en[c]) r[95 - 24 * c -: 24] = d[24 * c +: 24];
        return r;
    endfunction

    task automatic check(input logic [119:0] seen, input logic [119:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (failures == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one host transfer; notes command words and the expected frame first
    task automatic send(input int nb, input logic [119:0] ex, input bit keep);
        logic [119:0] tx;
        int n;
        tx = 120'({rnd(), rnd(), rnd(), rnd()});
        for (int w = 0; w < nb / 24; w++) if (!stall || held < 16) begin
            exp_cmd.push_back(tx[119 - 24 * w -: 24]);
            if (stall) held++;
        end
        if (keep) exp_frm.push_back(ex);
        go    <= 1'b1;
        nbits <= 7'(nb);
        tx_q  <= tx;
        @(posedge clk_sys_in);
        go <= 1'b0;
        n = 0;
        do begin @(posedge clk_sys_in); n++; end while (busy === 1'b1 && n < 1500);
        if (n >= 1500) check(120'h0, 120'h1);
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do begin @(posedge clk_sys_in); n++; end
        while (conversion_ready_n_out !== 1'b0 && n < 3500);
        if (n >= 3500) check(120'h0, 120'h1);
    endtask

    task automatic pulse_sync();
        sync_n_in <= 1'b0;
        repeat (10) @(posedge clk_sys_in);
        sync_n_in <= 1'b1;
        repeat (10) @(posedge clk_sys_in);
    endtask

    // master clock from the host; its rises are counted for cadence
    always @(posedge clk_sys_in) begin
        mdiv <= (mdiv == 99) ? 0 : mdiv + 1;
        if (mdiv == 99) begin
            master_clock_in <= ~master_clock_in;
            mclk_edges      <= mclk_edges + int'(!master_clock_in);
        end
    end

    // watchers: ready spacing, released output, command stream, frames
    always @(posedge clk_sys_in) begin
        rdy_prev <= conversion_ready_n_out;
        if (rdy_prev === 1'b1 && conversion_ready_n_out === 1'b0) begin
            ready_gap <= mclk_edges - last_edge;
            last_edge <= mclk_edges;
        end
        cs_run <= (cs_n === 1'b1) ? cs_run + 1 : 0;
        if (cs_run >= 6) check(120'(miso_oe_n_out), 120'h1);
        if (rst_n_in && cmd_valid_out === 1'b1 && cmd_ready_in) begin
            if (exp_cmd.size() == 0) check(120'h1, 120'h0);
            else check(120'(cmd_word_out), 120'(exp_cmd.pop_front()));
        end
        cmd_ready_in <= ~stall & rs[0]; // held low while stall is set to back up the fifo, random otherwise
        rs <= lfsr(rs);
        if (done === 1'b1) begin
            if (exp_frm.size() == 0) check(120'h1, 120'h0);
            else check(rx, exp_frm.pop_front());
        end
    end

    initial begin
        repeat (60000) @(posedge clk_sys_in);
        failures++;
        give_verdict();
    end

    initial begin
        {rst_n_in, clear_overrun_in, go, tie, stall} = 5'h00;
        {sync_n_in, crc_en_in} = 2'h3;
        ch_data_in = '0;
        ch_en_in = 4'hF;
        nbits = 7'h00;
        tx_q = '0;
        repeat (6) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        repeat (5) @(posedge clk_sys_in);
        check(120'({conversion_ready_n_out, miso_oe_n_out, realign_fault_flag_out,
                    overflow_out, crc_fault_out, cmd_valid_out}), 120'h30);
        send(120, frame(1'b0, 1'b0, 1'b1, 96'h0, 4'h0), 1'b1); // empty queue
        repeat (60) @(posedge clk_sys_in);
        // reads after each ready, with the command fifo stalled until it refuses
        stall <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            data = {rnd(), rnd(), rnd()};
            ch_data_in <= data;
            ch_en_in <= (k == 0) ? 4'hA : 4'(rnd());
            wait_ready();
            send(120, frame(1'b0, 1'b0, 1'b0, data, ch_en_in), 1'b1);
        end
        check(120'(ready_gap), 120'h8);
        check(120'(cmd_overrun_out), 120'h1);
        clear_overrun_in <= 1'b1;
        stall <= 1'b0;
        @(posedge clk_sys_in);
        clear_overrun_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        check(120'(cmd_overrun_out), 120'h0);
        // cut frame leaves the result in place
        data = {rnd(), rnd(), rnd()};
        ch_data_in <= data;
        wait_ready();
        ch_data_in <= {rnd(), rnd(), rnd()};
        send(48, '0, 1'b0);
        repeat (20) @(posedge clk_sys_in);
        send(120, frame(1'b0, 1'b0, 1'b0, data, ch_en_in), 1'b1);
        // misaligned strobe, then one on the conversion cadence
        data = {rnd(), rnd(), rnd()};
        ch_data_in <= data;
        wait_ready();
        repeat (3) @(posedge master_clock_in);
        repeat (10) @(posedge clk_sys_in);
        e0 = mclk_edges;
        pulse_sync();
        check(120'(realign_fault_flag_out), 120'h1);
        send(120, frame(1'b1, 1'b0, 1'b0, data, ch_en_in), 1'b1);
        check(120'(realign_fault_flag_out), 120'h0);
        while (mclk_edges != e0 + 8) @(posedge clk_sys_in);
        repeat (9) @(posedge clk_sys_in);
        pulse_sync();
        check(120'(realign_fault_flag_out), 120'h0);
        // select held low, nothing read: queue overflows
        tie <= 1'b1;
        repeat (3600) @(posedge clk_sys_in);
        check(120'(crc_fault_out), 120'h0);
        crc_en_in <= 1'b0;
        repeat (6400) @(posedge clk_sys_in);
        check(120'(crc_fault_out), 120'h1);
        check(120'(ready_gap), 120'h10);
        check(120'(overflow_out), 120'h1);
        tie <= 1'b0;
        crc_en_in <= 1'b1;
        repeat (30) @(posedge clk_sys_in);
        send(120, frame(1'b0, 1'b1, 1'b0, data, ch_en_in), 1'b1);
        check(120'(overflow_out), 120'h0);
        repeat (100) @(posedge clk_sys_in);
        check(120'(exp_cmd.size()), 120'h0);
        check(120'(exp_frm.size()), 120'h0);
        give_verdict();
    end
endmodule
